// ===== hdl/sfs_pkg.sv
`default_nettype none
package sfs_pkg;

    // Clock rate of the block
    localparam int CLK_MHZ          = 25;
    // Number of power channels that can be sensed
    localparam int NUM_CH           = 5;

    // Fixed strobe period while the PWM clock has failed
    localparam int SYNC_DEFAULT_NS  = 6_500_000;
    localparam int SYNC_DEFAULT_CYC = SYNC_DEFAULT_NS * CLK_MHZ / 1000;
    // Overflow marker pulse at full duty, typical length
    localparam int FULL_PULSE_NS    = 100_000;
    localparam int FULL_PULSE_CYC   = (FULL_PULSE_NS * CLK_MHZ + 999) / 1000;
    // Turn-on delay plus feedback settling; plain default, not a device figure
    localparam int SETTLE_NS        = 100_000;
    localparam int SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    // Lowest prescaler setting: period of the voltage-source strobe
    localparam int PRESCALE_DIV     = 1024;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Control field positions
    localparam int CTRL_SRC_LSB  = 0;
    localparam int CTRL_MODE_LSB = 3;
    localparam int CTRL_CHOP_LSB = 5;

    // Status bit positions
    localparam int ST_NORMAL  = 0;
    localparam int ST_CLKFAIL = 1;
    localparam int ST_POLAR   = 2;
    localparam int ST_STROBE  = 3;
    localparam int ST_BLANK   = 4;
    localparam int ST_FAULT   = 5;
    localparam int ST_WAITCYC = 6;
    localparam int ST_WAITMID = 7;

    // Feedback source codes; 1 to 5 select a channel current
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_CH1  = 3'h1;
    localparam logic [2:0] SRC_CH5  = 3'h5;
    localparam logic [2:0] SRC_TEMP = 3'h6;
    localparam logic [2:0] SRC_VBAT = 3'h7;

    // Device operating mode, given by the mode controller
    typedef enum logic [1:0] {
        OPM_SLEEP  = 2'b00,
        OPM_NORMAL = 2'b01,
        OPM_FAIL   = 2'b10
    } sfs_opmode_t;

    // Strobe behaviour selection
    typedef enum logic [1:0] {
        STROBE_OFF             = 2'b00,
        STROBE_VALID           = 2'b01,
        STROBE_NEXT_CYCLE_MODE = 2'b10,
        STROBE_HALF_PULSE_MODE = 2'b11
    } sfs_strobe_mode_t;

endpackage
`default_nettype wire

// ===== hdl/sfs_tmr_if.sv
`default_nettype none
// Start and busy pair between the controller and a one-shot timer
interface sfs_tmr_if;
    logic start;    // Restart the timer
    logic busy;     // Timer running
    modport ctrl (output start, input busy);
    modport tmr  (input start, output busy);
endinterface
`default_nettype wire

// ===== hdl/sfs_oneshot.sv
`default_nettype none
// Retriggerable one-shot: busy for LEN cycles after the last start
module sfs_oneshot #(
    parameter int LEN = 8
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sfs_tmr_if.tmr    tmr
);
    localparam int W = $clog2(LEN + 1);

    logic [W-1:0] cnt;       // Remaining cycles
    logic [W-1:0] next_cnt;

    // A new start reloads, so back-to-back events extend the window
    always_comb begin
        if (tmr.start) begin
            next_cnt = W'(LEN);
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else begin
            next_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tmr.busy = (cnt != '0);
endmodule
`default_nettype wire

// ===== hdl/sfs_square.sv
`default_nettype none
// Free square wave, HALF cycles per level, held low while disabled
module sfs_square #(
    parameter int HALF = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    output logic      level
);
    localparam int W = $clog2(HALF + 1);

    logic [W-1:0] cnt;          // Cycles spent in current level
    logic [W-1:0] next_cnt;
    logic         next_level;

    // Restart from low phase each time the wave is enabled
    always_comb begin
        next_cnt   = cnt + 1'b1;
        next_level = level;
        if (!en) begin
            next_cnt   = '0;
            next_level = 1'b0;
        end else if (cnt == W'(HALF - 1)) begin
            next_cnt   = '0;
            next_level = ~level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt   <= '0;
            level <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            level <= next_level;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/sfs_sense_sync.sv
// Notes on behaviour
// - Feedback and strobe only in normal mode
// - Source select field routes feedback multiplexer
// - No current feedback during inrush window
// - Current feedback only during on phase
// - Chop mode flips offset on strobe release
// - Per-channel chop enable, default off, off in fail
// - Chop mode halves low overcurrent threshold
// - Off setting holds strobe released high
// - Valid setting: low while feedback valid
// - Next-cycle setting waits for new PWM cycle
// - Half-pulse setting: low from pulse middle
// - No strobe during inrush or off phase
// - Blank after mux change or offset flip
// - Clock fail gives 6.5 ms square wave
// - Full duty, next-cycle and half-pulse settings: low, 100 us overflow pulse
// - No trigger while output faulted until re-enabled
// - Voltage source gives clock/1024 square wave
`default_nettype none
module sfs_sense_sync
    import sfs_pkg::*;
#(
    parameter int ADDR_W      = 12,
    parameter int DEFAULT_CYC = sfs_pkg::SYNC_DEFAULT_CYC,
    parameter int SETTLE      = sfs_pkg::SETTLE_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire sfs_pkg::sfs_opmode_t      op_mode,
    input  wire logic [sfs_pkg::NUM_CH-1:0] pwm_on,
    input  wire logic [sfs_pkg::NUM_CH-1:0] pwm_second_half,
    input  wire logic [sfs_pkg::NUM_CH-1:0] pwm_full_duty,
    input  wire logic                      pwm_cycle_start,
    input  wire logic                      pwm_clock_fail,
    input  wire logic [sfs_pkg::NUM_CH-1:0] inrush_overcurrent_window,
    input  wire logic [sfs_pkg::NUM_CH-1:0] output_fault,
    input  wire logic [sfs_pkg::NUM_CH-1:0] output_enable,
    output logic                           analog_feedback_out_en,
    output logic      [2:0]                feedback_source,
    output logic                           current_feedback_gate,
    output logic                           offset_chop_polarity,
    output logic [sfs_pkg::NUM_CH-1:0]     low_overcurrent_threshold_halve,
    output logic                           feedback_sample_strobe_n_out,
    output logic                           feedback_sample_strobe_n_oe
);
    import sfs_pkg::*;

    // True when the source code names a channel current
    function automatic logic is_current(input logic [2:0] src);
        is_current = (src >= SRC_CH1) && (src <= SRC_CH5);
    endfunction

    // Channel index of a current source, 0 otherwise
    function automatic logic [2:0] chan_of(input logic [2:0] src);
        chan_of = is_current(src) ? (src - SRC_CH1) : 3'h0;
    endfunction

    // Software control and its decoded fields
    logic [31:0]            ctrl;
    logic [31:0]            next_ctrl;
    logic [2:0]             src;
    sfs_strobe_mode_t       mode;
    logic [NUM_CH-1:0]      chop_en;
    assign src     = ctrl[CTRL_SRC_LSB +: 3];
    assign mode    = sfs_strobe_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
    assign chop_en = ctrl[CTRL_CHOP_LSB +: NUM_CH];

    // Bus answer registers
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;

    // Edge history and sticky state
    logic [2:0]             prev_src;
    logic                   prev_on;
    logic                   prev_half;
    logic                   prev_oe;         // Strobe level one cycle ago
    logic [NUM_CH-1:0]      prev_enable;
    logic [NUM_CH-1:0]      fault_hold;
    logic [NUM_CH-1:0]      next_fault_hold;
    logic                   wait_cycle;
    logic                   next_wait_cycle;
    logic                   wait_mid;
    logic                   next_wait_mid;
    logic                   next_polarity;
    logic                   next_strobe;

    // Registered feedback outputs
    logic                   next_fb_en;
    logic [2:0]             next_fb_src;
    logic                   next_gate;
    logic [NUM_CH-1:0]      next_halve;

    // Decoded conditions
    logic                   normal;
    logic                   cur;
    logic                   volt;
    logic [2:0]             ch;
    logic                   on_sel;
    logic                   half_sel;
    logic                   full_sel;
    logic                   inrush_sel;
    logic [NUM_CH-1:0]      chop_eff;
    logic                   mux_change;
    logic                   chop_toggle;
    logic                   blank;
    logic                   base_ok;
    logic                   half_rise;
    logic                   slow_level;
    logic                   fast_level;
    logic                   wr_en;

    // Timers shared through the start/busy carrier
    sfs_tmr_if blank_if ();
    sfs_tmr_if pulse_if ();

    sfs_oneshot #(.LEN(SETTLE)) u_blank (
        .clk   (clk),
        .rst_n (rst_n),
        .tmr   (blank_if)
    );

    sfs_oneshot #(.LEN(FULL_PULSE_CYC)) u_pulse (
        .clk   (clk),
        .rst_n (rst_n),
        .tmr   (pulse_if)
    );

    sfs_square #(.HALF(DEFAULT_CYC / 2)) u_slow (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (normal && pwm_clock_fail),
        .level (slow_level)
    );

    sfs_square #(.HALF(PRESCALE_DIV / 2)) u_fast (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (normal && volt),
        .level (fast_level)
    );

    // Source decode and per-channel selection
    assign normal     = (op_mode == OPM_NORMAL);
    assign cur        = is_current(src);
    assign volt       = (src == SRC_TEMP) || (src == SRC_VBAT);
    assign ch         = chan_of(src);
    assign on_sel     = cur && pwm_on[ch];
    assign half_sel   = cur && pwm_second_half[ch];
    assign full_sel   = cur && pwm_full_duty[ch];
    assign inrush_sel = cur && inrush_overcurrent_window[ch];
    assign chop_eff   = normal ? chop_en : '0;

    // Events; strobe release is the rising edge of the pin
    assign mux_change = (src != prev_src);
    // flip on strobe release
    // Registered release edge, so the flip cannot loop back via blanking
    assign chop_toggle = prev_oe && !feedback_sample_strobe_n_oe
                         && cur && chop_eff[ch];
    assign half_rise  = half_sel && !prev_half;
    assign blank_if.start = mux_change || (on_sel && !prev_on) || chop_toggle;
    // The start itself blanks, so blanking has no one-cycle hole
    assign blank      = blank_if.busy || blank_if.start;
    assign pulse_if.start = pwm_cycle_start && full_sel;
    assign wr_en      = psel && penable && pready && pwrite;

    // APB slave: zero wait states, unmapped offsets answer an error
    always_comb begin
        next_ctrl    = ctrl;
        next_prdata  = 32'h0000_0000;
        next_pready  = psel && !penable;
        next_pslverr = 1'b0;
        if (wr_en && (paddr == ADDR_W'(OFS_CTRL))) begin
            next_ctrl = pwdata;
        end
        if (psel && !penable) begin
            if (paddr == ADDR_W'(OFS_CTRL)) begin
                next_prdata = ctrl;
            end else if (paddr == ADDR_W'(OFS_STATUS)) begin
                next_prdata[ST_NORMAL]  = normal;
                next_prdata[ST_CLKFAIL] = pwm_clock_fail;
                next_prdata[ST_POLAR]   = offset_chop_polarity;
                next_prdata[ST_STROBE]  = feedback_sample_strobe_n_oe;
                next_prdata[ST_BLANK]   = blank_if.busy;
                next_prdata[ST_FAULT]   = fault_hold[ch];
                next_prdata[ST_WAITCYC] = wait_cycle;
                next_prdata[ST_WAITMID] = wait_mid;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    // Sense path: what reaches the analog feedback pin
    always_comb begin
        next_fb_en  = normal && (src != SRC_NONE);
        next_fb_src = normal ? src : SRC_NONE;
        next_gate   = normal && on_sel && !inrush_sel;
        next_halve  = chop_eff;
        next_polarity = chop_toggle ? !offset_chop_polarity
                                    : offset_chop_polarity;
    end

    // Sticky qualifiers of the strobe; every set wins over its clear
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_fault_hold[i] = output_fault[i] || (fault_hold[i]
                                 && !(output_enable[i] && !prev_enable[i]));
        end
        next_wait_cycle = mux_change || (wait_cycle && !pwm_cycle_start);
        next_wait_mid   = mux_change || (wait_mid && !half_rise);
    end

    // Strobe level; 1 means the pin is pulled low
    always_comb begin
        // off phase and inrush suppressed
        // A fault arriving this cycle already silences the strobe
        base_ok     = on_sel && !inrush_sel && !blank
                      && !next_fault_hold[ch];
        next_strobe = 1'b0;
        if (!normal) begin
            next_strobe = 1'b0;
        end else if (pwm_clock_fail) begin
            next_strobe = slow_level;
        end else if (volt) begin
            next_strobe = fast_level;
        end else if (cur) begin
            case (mode)
                STROBE_OFF: begin
                    next_strobe = 1'b0;
                end
                STROBE_VALID: begin
                    next_strobe = base_ok;
                end
                STROBE_NEXT_CYCLE_MODE: begin
                    if (full_sel) begin
                        next_strobe = !pulse_if.busy && !pulse_if.start
                                      && !inrush_sel
                                      && !next_fault_hold[ch];
                    end else begin
                        next_strobe = base_ok && !wait_cycle;
                    end
                end
                STROBE_HALF_PULSE_MODE: begin
                    if (full_sel) begin
                        next_strobe = !pulse_if.busy && !pulse_if.start
                                      && !inrush_sel
                                      && !next_fault_hold[ch];
                    end else begin
                        next_strobe = base_ok && !wait_mid && half_sel;
                    end
                end
                default: begin
                    next_strobe = 1'b0;
                end
            endcase
        end
    end

    // State registers of the block; the timer and square-wave counters sit in their submodules
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl                            <= CTRL_RESET;
            prdata                          <= 32'h0000_0000;
            pready                          <= 1'b0;
            pslverr                         <= 1'b0;
            prev_src                        <= SRC_NONE;
            prev_on                         <= 1'b0;
            prev_half                       <= 1'b0;
            prev_oe                         <= 1'b0;
            prev_enable                     <= '0;
            fault_hold                      <= '0;
            wait_cycle                      <= 1'b0;
            wait_mid                        <= 1'b0;
            analog_feedback_out_en          <= 1'b0;
            feedback_source                 <= SRC_NONE;
            current_feedback_gate           <= 1'b0;
            offset_chop_polarity            <= 1'b0;
            low_overcurrent_threshold_halve <= '0;
            feedback_sample_strobe_n_out    <= 1'b0;
            feedback_sample_strobe_n_oe     <= 1'b0;
        end else begin
            ctrl                            <= next_ctrl;
            prdata                          <= next_prdata;
            pready                          <= next_pready;
            pslverr                         <= next_pslverr;
            prev_src                        <= src;
            prev_on                         <= on_sel;
            prev_half                       <= half_sel;
            prev_oe                         <= feedback_sample_strobe_n_oe;
            prev_enable                     <= output_enable;
            fault_hold                      <= next_fault_hold;
            wait_cycle                      <= next_wait_cycle;
            wait_mid                        <= next_wait_mid;
            analog_feedback_out_en          <= next_fb_en;
            feedback_source                 <= next_fb_src;
            current_feedback_gate           <= next_gate;
            offset_chop_polarity            <= next_polarity;
            low_overcurrent_threshold_halve <= next_halve;
            // Open drain: the pin only ever drives low
            feedback_sample_strobe_n_out    <= 1'b0;
            feedback_sample_strobe_n_oe     <= next_strobe;
        end
    end

    // Checks on the registered outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence mux_step;
        mux_change && cur && normal && !pwm_clock_fail;
    endsequence

    chk_not_normal_quiet: assert property (
        !normal |=> !feedback_sample_strobe_n_oe && !analog_feedback_out_en)
        else $error("strobe or feedback active outside normal mode");
    chk_source_route: assert property (
        normal |=> feedback_source == $past(src))
        else $error("feedback source does not follow select field");
    chk_inrush_gate: assert property (
        inrush_sel |=> !current_feedback_gate)
        else $error("current feedback during inrush window");
    chk_on_phase_gate: assert property (
        !on_sel |=> !current_feedback_gate)
        else $error("current feedback outside on phase");
    chk_chop_flip: assert property (
        chop_toggle |=> offset_chop_polarity != $past(offset_chop_polarity))
        else $error("offset polarity did not flip on strobe release");
    chk_chop_fail_off: assert property (
        op_mode == OPM_FAIL |=> low_overcurrent_threshold_halve == '0)
        else $error("chop mode active in fail mode");
    chk_halve_follow: assert property (
        normal |=> low_overcurrent_threshold_halve == $past(chop_en))
        else $error("threshold halving does not follow chop enable");
    chk_off_setting: assert property (
        normal && cur && mode == STROBE_OFF && !pwm_clock_fail
        |=> !feedback_sample_strobe_n_oe)
        else $error("strobe active in off setting");
    chk_valid_follow: assert property (
        normal && cur && mode == STROBE_VALID && !pwm_clock_fail
        |=> feedback_sample_strobe_n_oe == $past(base_ok))
        else $error("valid setting strobe mismatch");
    chk_next_cycle: assert property (
        mux_step and mode == STROBE_NEXT_CYCLE_MODE && !full_sel
        && !pwm_cycle_start |=> ##1 !feedback_sample_strobe_n_oe)
        else $error("strobe before next PWM cycle after mux change");
    chk_half_wait: assert property (
        normal && cur && !pwm_clock_fail && !full_sel && !half_sel
        && mode == STROBE_HALF_PULSE_MODE |=> !feedback_sample_strobe_n_oe)
        else $error("half-pulse strobe before pulse middle");
    chk_off_phase: assert property (
        normal && cur && !pwm_clock_fail && !full_sel
        && (!on_sel || inrush_sel) |=> !feedback_sample_strobe_n_oe)
        else $error("strobe in off phase or inrush");
    chk_mux_blank: assert property (
        mux_step and !full_sel |=> !feedback_sample_strobe_n_oe [*2])
        else $error("strobe not blanked after mux change");
    chk_clock_fail_wave: assert property (
        normal && pwm_clock_fail
        |=> feedback_sample_strobe_n_oe == $past(slow_level))
        else $error("strobe not on default wave at clock fail");
    chk_full_pulse: assert property (
        pulse_if.start && normal && !pwm_clock_fail && mode[1]
        |=> !feedback_sample_strobe_n_oe ##1 pulse_if.busy)
        else $error("no overflow pulse at full duty");
    chk_fault_silent: assert property (
        normal && cur && next_fault_hold[ch] && !pwm_clock_fail
        |=> !feedback_sample_strobe_n_oe)
        else $error("strobe trigger while output faulted");
    chk_voltage_wave: assert property (
        normal && volt && !pwm_clock_fail
        |=> feedback_sample_strobe_n_oe == $past(fast_level))
        else $error("voltage source strobe not on prescaler wave");
endmodule
`default_nettype wire

// ===== dv/sfs_adc_model.sv
`default_nettype none
// Controller ADC: takes a sample at each strobe assertion on the wire
module sfs_adc_model (
    input  wire logic clk,
    input  wire logic strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned samples = 0;    // Samples taken
    int unsigned pairs   = 0;    // Offset-free averaged readings
    logic        was_n   = 1'b1; // Strobe level one cycle ago
    // pair averaging
    // Two samples of opposite offset sign make one reading
    always @(posedge clk) begin
        if (was_n && !strobe_n) begin
            samples++;
        end
        pairs = samples / 2;
        was_n = strobe_n;
    end
endmodule
`default_nettype wire

// ===== dv/sense_feedback_sync_control_bench.sv
`default_nettype none
module sense_feedback_sync_control_bench;
    import sfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEF = 40; // Short clock-fail period keeps the run brief
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cf, cs;
    logic fb_en, gate, pol, s_out, s_oe, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  src;
    logic [4:0]  on, inr, flt, oen, halve, hf, fd;
    sfs_opmode_t op_mode;
    int num_errors = 0, total_checks = 0, cyc = 0;
    wire strobe_n = s_oe ? s_out : 1'b1; // Pull-up when released
    sfs_sense_sync #(.DEFAULT_CYC(DEF), .SETTLE(8)) sfs_sense_sync_i (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
        .pwm_on(on), .pwm_second_half(hf), .pwm_full_duty(fd),
        .pwm_cycle_start(cs), .pwm_clock_fail(cf),
        .inrush_overcurrent_window(inr), .output_fault(flt),
        .output_enable(oen), .analog_feedback_out_en(fb_en),
        .feedback_source(src), .current_feedback_gate(gate),
        .offset_chop_polarity(pol), .low_overcurrent_threshold_halve(halve),
        .feedback_sample_strobe_n_out(s_out),
        .feedback_sample_strobe_n_oe(s_oe));
    sfs_adc_model sfs_adc_model_i (.clk(clk), .strobe_n(strobe_n));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("Errors %0d, checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; answer taken at the edge that samples pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Cycles one strobe level is held
    task automatic half_len(output int n);
        logic v;
        @(negedge clk);
        v = s_oe;
        while (s_oe === v) @(negedge clk);
        v = s_oe;
        n = 0;
        while (s_oe === v) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_regs();
        apb(1'b0, OFS_CTRL, 32'h0);
        check(r, CTRL_RESET); // chop off
        apb(1'b0, 12'h008, 32'h0);
        check(e, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0000_0029);
        wt(3);
        check({fb_en, s_oe}, 2'b00); // sleep silent
        @(posedge clk) op_mode <= OPM_NORMAL;
        wt(3);
        check({fb_en, src, halve}, {1'b1, 3'h1, 5'h01});
    endtask
    task automatic t_valid();
        logic p;
        @(posedge clk) on <= 5'h01;
        wt(12);
        check({s_oe, gate}, 2'b11); // valid strobe
        p = pol;
        @(posedge clk) on <= 5'h00;
        wt(3);
        check({s_oe, gate, pol}, {2'b00, ~p});
        @(posedge clk) begin
            on <= 5'h01;
            inr <= 5'h01;
        end
        wt(12);
        check({s_oe, gate}, 2'b00); // inrush
        @(posedge clk) begin
            inr <= 5'h00;
            flt <= 5'h01;
        end
        @(posedge clk) flt <= 5'h00;
        wt(12);
        check(s_oe, 1'b0); // fault hold
        @(posedge clk) oen <= 5'h00;
        @(posedge clk) oen <= 5'h1f;
        wt(12);
        check(s_oe, 1'b1); // re-enabled
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wt(12);
        check(s_oe, 1'b0); // off mode
        check(sfs_adc_model_i.pairs, 32'd1); // two samples, one pair
    endtask
    task automatic t_modes();
        apb(1'b1, OFS_CTRL, 32'h0000_0012);
        apb(1'b1, OFS_CTRL, 32'h0000_0011);
        wt(12);
        check(s_oe, 1'b0); // wait for new cycle
        @(posedge clk) cs <= 1'b1;
        @(posedge clk) cs <= 1'b0;
        wt(4);
        check(s_oe, 1'b1); // new cycle started
        @(posedge clk) begin
            fd <= 5'h01;
            cs <= 1'b1;
        end
        @(posedge clk) cs <= 1'b0;
        wt(10);
        check(s_oe, 1'b0); // overflow pulse
        wt(FULL_PULSE_CYC);
        check(s_oe, 1'b1); // back low
        @(posedge clk) fd <= 5'h00;
        apb(1'b1, OFS_CTRL, 32'h0000_0019);
        wt(4);
        check(s_oe, 1'b0); // before pulse middle
        @(posedge clk) hf <= 5'h01;
        wt(4);
        check(s_oe, 1'b1); // from pulse middle
        @(posedge clk) hf <= 5'h00;
        wt(3);
        check(s_oe, 1'b0); // pulse end
    endtask
    task automatic t_waves();
        int n;
        apb(1'b1, OFS_CTRL, 32'h0000_0007);
        half_len(n);
        check(n, PRESCALE_DIV / 2); // voltage wave
        @(posedge clk) cf <= 1'b1;
        wt(4);
        half_len(n);
        check(n, DEF / 2); // clock fail wave
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, cf} = '0;
        {paddr, pwdata, on, inr, flt, hf, fd, cs} = '0;
        oen = 5'h1f;
        op_mode = OPM_SLEEP;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_valid();
        t_modes();
        t_waves();
        tally_and_finish();
    end
endmodule
`default_nettype wire
